// [inc/tap_port_pkg.sv]
// Constants, instruction codes and controller states for the boundary-scan test port
package tap_port_pkg;

	// Register sizes
	localparam int          IR_WIDTH     = 3;
	localparam int          ID_WIDTH     = 32;
	localparam int          TMS_RST_EDGES = 5;
	localparam int          CNT_WIDTH    = 3;

	// Instruction codes
	localparam logic [2:0]  INS_EXTEST   = 3'h0;
	localparam logic [2:0]  INS_IDCODE   = 3'h1;
	localparam logic [2:0]  INS_SAMPLE_Z = 3'h2;
	localparam logic [2:0]  INS_SAMPLE   = 3'h4;
	localparam logic [2:0]  INS_BYPASS   = 3'h7;

	// Values loaded on capture and after reset
	localparam logic [1:0]  IR_CAPT_LOW  = 2'h1;
	localparam logic        IR_CAPT_HIGH = 1'h0;
	localparam logic        BYP_CAPT     = 1'h0;
	localparam logic        PULL_UP_VAL  = 1'h1;
	localparam logic        TCK_RST_VAL  = 1'h0;

	// Controller states, Gray-coded along the scan path
	typedef enum logic [3:0] {
		ST_RESET    = 4'h0,
		ST_IDLE     = 4'h1,
		ST_SEL_DR   = 4'h3,
		ST_CAP_DR   = 4'h2,
		ST_SHIFT_DR = 4'h6,
		ST_EX1_DR   = 4'h7,
		ST_PAUSE_DR = 4'h5,
		ST_EX2_DR   = 4'h4,
		ST_UPD_DR   = 4'hC,
		ST_SEL_IR   = 4'hD,
		ST_CAP_IR   = 4'hF,
		ST_SHIFT_IR = 4'hE,
		ST_EX1_IR   = 4'hA,
		ST_PAUSE_IR = 4'hB,
		ST_EX2_IR   = 4'h9,
		ST_UPD_IR   = 4'h8
	} tap_state_e;

endpackage

// [hw/tap_port.sv]
// Boundary-scan test access port sampled on the system clock
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - All port inputs are taken at rising test clock; the falling edge drives only the serial output and its enable.
// - The serial output changes only at a falling test clock edge.
// - Mode select is the controller command, taken at each rising test clock edge.
// - Next state follows the standard scan graph from mode select, 0 or 1.
// - A floating mode select reads high through the internal pull-up; here only the synchroniser resets high, until the pin is seen.
// - A floating data input reads high, so the port may be left unused; here only the synchroniser resets high, until the pin is seen.
// - Only the register chosen by the current instruction sits in the data path.
// - Serial input enters the chosen register at its top bit.
// - The chosen register's bottom bit is the one driven on serial output.
// - The output driver is on only in the two shift states.
// - Port holds controller, instruction, boundary, bypass and identification registers.
// - Power-up enters reset by itself and never disturbs memory operation.
// - Port never disturbs fully compliant scan devices in the same chain.
// - Five rising edges with mode select high always return to reset.
// - The instruction register is three bits, loaded serially in the scan path.
// - Reset and power-up load the identification instruction.
// - Instruction capture loads pattern 01 into the two low bits.
module tap_port
	import tap_port_pkg::*;
#(
	parameter int               BSR_WIDTH = 16,
	parameter logic [31:0]      ID_VALUE  = 32'h1234_5671 // Arbitrary identification value
)(
	// System clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 reset_n,
	// Test port pins
	input  wire logic                 tck,
	input  wire logic                 tms,
	input  wire logic                 tdi,
	output logic                      tdo,
	output logic                      tdo_oe,
	// Memory pad ring
	input  wire logic [BSR_WIDTH-1:0] io_ring,
	output logic                      pads_hiz
);

	// Synchroniser stages; first stages feed only the second ones
	logic                 tck_m_ff, tck_s_ff, tck_d_ff;
	logic                 tms_m_ff, tms_s_ff;
	logic                 tdi_m_ff, tdi_s_ff;
	logic [BSR_WIDTH-1:0] io_m_ff, io_s_ff;
	logic                 tck_rise, tck_fall;

	// Controller and scan registers
	tap_state_e           state_ff, nxt_state;
	logic [IR_WIDTH-1:0]  ir_ff, ir_shift_ff;
	logic [ID_WIDTH-1:0]  id_ff;
	logic [BSR_WIDTH-1:0] bsr_ff;
	logic                 byp_ff;
	logic                 tdo_ff, tdo_oe_ff, hiz_ff;

	// Pull-ups: mode select and data in rest high until the pins are seen
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tms_m_ff <= PULL_UP_VAL;
			tms_s_ff <= PULL_UP_VAL;
			tdi_m_ff <= PULL_UP_VAL;
			tdi_s_ff <= PULL_UP_VAL;
		end
		else
		begin
			tms_m_ff <= tms;
			tms_s_ff <= tms_m_ff;
			tdi_m_ff <= tdi;
			tdi_s_ff <= tdi_m_ff;
		end
	end

	// Test clock sampling; a clock held low yields no edges at all
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tck_m_ff <= TCK_RST_VAL;
			tck_s_ff <= TCK_RST_VAL;
			tck_d_ff <= TCK_RST_VAL;
		end
		else
		begin
			tck_m_ff <= tck;
			tck_s_ff <= tck_m_ff;
			tck_d_ff <= tck_s_ff;
		end
	end

	// Edge strobes share the synchroniser delay with mode select and data in
	assign tck_rise = tck_s_ff & ~tck_d_ff;
	assign tck_fall = ~tck_s_ff & tck_d_ff;

	// Pad ring arrives from the memory clock; capture may still catch a moving pad
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			io_m_ff <= '0;
			io_s_ff <= '0;
		end
		else
		begin
			io_m_ff <= io_ring;
			io_s_ff <= io_m_ff;
		end
	end

	// Standard scan graph driven by mode select
	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_RESET:    nxt_state = tms_s_ff ? ST_RESET   : ST_IDLE;
			ST_IDLE:     nxt_state = tms_s_ff ? ST_SEL_DR  : ST_IDLE;
			ST_SEL_DR:   nxt_state = tms_s_ff ? ST_SEL_IR  : ST_CAP_DR;
			ST_CAP_DR:   nxt_state = tms_s_ff ? ST_EX1_DR  : ST_SHIFT_DR;
			ST_SHIFT_DR: nxt_state = tms_s_ff ? ST_EX1_DR  : ST_SHIFT_DR;
			ST_EX1_DR:   nxt_state = tms_s_ff ? ST_UPD_DR  : ST_PAUSE_DR;
			ST_PAUSE_DR: nxt_state = tms_s_ff ? ST_EX2_DR  : ST_PAUSE_DR;
			ST_EX2_DR:   nxt_state = tms_s_ff ? ST_UPD_DR  : ST_SHIFT_DR;
			ST_UPD_DR:   nxt_state = tms_s_ff ? ST_SEL_DR  : ST_IDLE;
			ST_SEL_IR:   nxt_state = tms_s_ff ? ST_RESET   : ST_CAP_IR;
			ST_CAP_IR:   nxt_state = tms_s_ff ? ST_EX1_IR  : ST_SHIFT_IR;
			ST_SHIFT_IR: nxt_state = tms_s_ff ? ST_EX1_IR  : ST_SHIFT_IR;
			ST_EX1_IR:   nxt_state = tms_s_ff ? ST_UPD_IR  : ST_PAUSE_IR;
			ST_PAUSE_IR: nxt_state = tms_s_ff ? ST_EX2_IR  : ST_PAUSE_IR;
			ST_EX2_IR:   nxt_state = tms_s_ff ? ST_UPD_IR  : ST_SHIFT_IR;
			ST_UPD_IR:   nxt_state = tms_s_ff ? ST_SEL_DR  : ST_IDLE;
		endcase
	end

	// Controller advances only on a rising test clock; power-up lands in reset
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			state_ff <= ST_RESET;
		else if (tck_rise)
			state_ff <= nxt_state;
	end

	// Instruction register: serial shift with top-bit entry, update, reset load
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ir_ff       <= INS_IDCODE;
			ir_shift_ff <= INS_IDCODE;
		end
		else if (tck_rise)
		begin
			if (nxt_state == ST_RESET)
				ir_ff <= INS_IDCODE;
			else if (state_ff == ST_UPD_IR)
				ir_ff <= ir_shift_ff;
			if (state_ff == ST_CAP_IR)
				ir_shift_ff <= {IR_CAPT_HIGH, IR_CAPT_LOW};
			else if (state_ff == ST_SHIFT_IR)
				ir_shift_ff <= {tdi_s_ff, ir_shift_ff[IR_WIDTH-1:1]};
		end
	end

	// Data registers: only the one the instruction picks captures or shifts
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			id_ff  <= '0;
			bsr_ff <= '0;
			byp_ff <= BYP_CAPT;
		end
		else if (tck_rise)
		begin
			unique case (ir_ff)
				INS_IDCODE:
				begin
					if (state_ff == ST_CAP_DR)
						id_ff <= ID_VALUE;
					else if (state_ff == ST_SHIFT_DR)
						id_ff <= {tdi_s_ff, id_ff[ID_WIDTH-1:1]};
				end
				INS_EXTEST, INS_SAMPLE_Z, INS_SAMPLE:
				begin
					// No preload: update of this register has no effect
					if (state_ff == ST_CAP_DR)
						bsr_ff <= io_s_ff;
					else if (state_ff == ST_SHIFT_DR)
						bsr_ff <= {tdi_s_ff, bsr_ff[BSR_WIDTH-1:1]};
				end
				default:
				begin
					// Bypass and the unused codes keep the chain one bit long
					if (state_ff == ST_CAP_DR)
						byp_ff <= BYP_CAPT;
					else if (state_ff == ST_SHIFT_DR)
						byp_ff <= tdi_s_ff;
				end
			endcase
		end
	end

	// Bottom bit of whatever register is in the path
	function automatic logic path_lsb(input tap_state_e st, input logic [IR_WIDTH-1:0] ins,
		input logic [IR_WIDTH-1:0] irs, input logic [ID_WIDTH-1:0] idr,
		input logic [BSR_WIDTH-1:0] bsr, input logic byp);
		logic bit_out;
		bit_out = byp;
		if (st == ST_SHIFT_IR)
			bit_out = irs[0];
		else if (ins == INS_IDCODE)
			bit_out = idr[0];
		else if (ins == INS_EXTEST || ins == INS_SAMPLE_Z || ins == INS_SAMPLE)
			bit_out = bsr[0];
		return bit_out;
	endfunction

	// Serial output moves on the falling edge, giving the far end half a period
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tdo_ff    <= 1'h0;
			tdo_oe_ff <= 1'h0;
		end
		else if (tck_fall)
		begin
			tdo_ff    <= path_lsb(state_ff, ir_ff, ir_shift_ff, id_ff, bsr_ff, byp_ff);
			tdo_oe_ff <= (state_ff == ST_SHIFT_DR) || (state_ff == ST_SHIFT_IR);
		end
	end

	// Memory outputs float under the two float-the-pads instructions
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			hiz_ff <= 1'h0;
		else
			hiz_ff <= (ir_ff == INS_EXTEST) || (ir_ff == INS_SAMPLE_Z);
	end

	assign tdo      = tdo_ff;
	assign tdo_oe   = tdo_oe_ff;
	assign pads_hiz = hiz_ff;

	// Helper: consecutive rising edges with mode select high
	logic [CNT_WIDTH-1:0] tms_hi_cnt_ff;
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			tms_hi_cnt_ff <= '0;
		else if (tck_rise)
		begin
			if (!tms_s_ff)
				tms_hi_cnt_ff <= '0;
			else if (tms_hi_cnt_ff != CNT_WIDTH'(TMS_RST_EDGES))
				tms_hi_cnt_ff <= tms_hi_cnt_ff + 1'h1;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	property p_tdo_on_fall;
		$changed(tdo_ff) |-> $past(tck_fall);
	endproperty
	a_tdo_on_fall: assert property (p_tdo_on_fall) else $error("serial out moved off a falling edge");

	property p_state_on_rise;
		(state_ff != $past(state_ff)) |-> $past(tck_rise);
	endproperty
	a_state_on_rise: assert property (p_state_on_rise) else $error("state moved off a rising edge");

	property p_five_high_reset;
		(tms_hi_cnt_ff == CNT_WIDTH'(TMS_RST_EDGES)) |-> (state_ff == ST_RESET);
	endproperty
	a_five_high_reset: assert property (p_five_high_reset) else $error("five high edges missed reset");

	property p_reset_idcode;
		(state_ff == ST_RESET) |-> (ir_ff == INS_IDCODE);
	endproperty
	a_reset_idcode: assert property (p_reset_idcode) else $error("reset state without id instruction");

	property p_capture_ir;
		$past(tck_rise) && ($past(state_ff) == ST_CAP_IR) |-> (ir_shift_ff[1:0] == IR_CAPT_LOW);
	endproperty
	a_capture_ir: assert property (p_capture_ir) else $error("capture pattern not loaded");

	property p_oe_in_shift;
		$rose(tdo_oe_ff) |-> ($past(state_ff) == ST_SHIFT_DR || $past(state_ff) == ST_SHIFT_IR);
	endproperty
	a_oe_in_shift: assert property (p_oe_in_shift) else $error("driver on outside shift");

	property p_float_in_reset;
		(state_ff == ST_RESET) |-> !tdo_oe_ff;
	endproperty
	a_float_in_reset: assert property (p_float_in_reset) else $error("driver on in reset state");

	property p_bypass_lsb;
		$past(tck_fall) && ($past(state_ff) == ST_SHIFT_DR) && ($past(ir_ff) == INS_BYPASS)
			|-> (tdo_ff == $past(byp_ff));
	endproperty
	a_bypass_lsb: assert property (p_bypass_lsb) else $error("bypass bit not on output");

	property p_msb_entry;
		$past(tck_rise) && ($past(state_ff) == ST_SHIFT_IR) |-> (ir_shift_ff[2] == $past(tdi_s_ff));
	endproperty
	a_msb_entry: assert property (p_msb_entry) else $error("input not at top bit");

	c_shift_id: cover property ((state_ff == ST_SHIFT_DR) && (ir_ff == INS_IDCODE));
	c_update_ir: cover property ((state_ff == ST_UPD_IR) ##[1:200] (ir_ff == INS_BYPASS));
	c_five_reset: cover property (tms_hi_cnt_ff == CNT_WIDTH'(TMS_RST_EDGES));
	c_drive_out: cover property ($rose(tdo_oe_ff));

endmodule
`default_nettype wire

// [test/scan_master_model.sv]
// Board test controller model that drives the scan link pins
`timescale 1ns/1ps
`default_nettype none
module scan_master_model (
	// Timing reference
	input  wire logic clk_sys,
	// Link pins
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	input  wire logic tdo_pin
);
	// Clock stands low between frames, so an idle port is never clocked
	initial
	begin
		tck = 1'h0;
		tms = 1'h1;
		tdi = 1'h1;
	end

	// One 48 ns link cycle; tdo is read late in the low phase, once settled
	task automatic step(input logic m, input logic d, output logic q);
	begin
		@(negedge clk_sys);
		tms = m;
		tdi = d;
		repeat (3) @(negedge clk_sys);
		q = tdo_pin;
		tck = 1'h1;
		repeat (6) @(negedge clk_sys);
		tck = 1'h0;
		repeat (2) @(negedge clk_sys);
		tdi = 1'h1;
	end
	endtask

	// Walks the state graph with mode select bits taken lsb first
	task automatic walk(input logic [7:0] seq, input int n);
		logic q;
	begin
		for (int i = 0; i < n; i++)
			step(seq[i], 1'h1, q);
	end
	endtask

	// Shifts n bits lsb first; the last one also leaves the shift state
	task automatic scan(input logic [63:0] din, input int n, output logic [63:0] dout);
		logic q;
	begin
		dout = '0;
		for (int i = 0; i < n; i++)
		begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
	end
	endtask

	// Five rises with mode select high reach reset from anywhere
	task automatic reset_link();
	begin
		walk(8'h1F, 5);
	end
	endtask
endmodule
`default_nettype wire

// [test/tap_port_tb.sv]
// Self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
`default_nettype none
module tap_port_tb;
	import tap_port_pkg::*;
	localparam int          BW  = 16;
	localparam logic [31:0] IDV = 32'hC0DE_0A5B; // Arbitrary identification value
	logic          clk_sys;
	logic          reset_n;
	logic          tck;
	logic          tms;
	logic          tdi;
	logic          tdo;
	logic          tdo_oe;
	logic          pads_hiz;
	logic [BW-1:0] io_ring;
	logic [63:0]   got;
	int            n_errors;
	int            checked;
	// Pin level as the board sees it
	wire           tdo_pin = tdo_oe ? tdo : 1'hZ;

	tap_port #(.BSR_WIDTH(BW), .ID_VALUE(IDV)) u_tap_port (
		.clk_sys(clk_sys), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo(tdo), .tdo_oe(tdo_oe), .io_ring(io_ring), .pads_hiz(pads_hiz));
	scan_master_model u_scan_master_model (
		.clk_sys(clk_sys), .tck(tck), .tms(tms), .tdi(tdi), .tdo_pin(tdo_pin));

	initial
	begin
		clk_sys = 1'h0;
		forever #2 clk_sys = ~clk_sys;
	end

	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] seen);
	begin
		checked++;
		if (exp !== seen)
		begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	end
	endtask

	task automatic end_of_test();
	begin
		if (n_errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	end
	endtask

	// Loads an instruction, judging the captured pattern on the way out
	task automatic load_ir(input logic [2:0] ins);
	begin
		u_scan_master_model.walk(8'h03, 4);
		u_scan_master_model.scan({61'h0, ins}, 3, got);
		chk("ir capture", 64'h1, got);
		u_scan_master_model.walk(8'h01, 2);
	end
	endtask

	// Idle to shift-DR, shift, back to idle
	task automatic scan_dr(input logic [63:0] din, input int n);
	begin
		u_scan_master_model.walk(8'h01, 3);
		u_scan_master_model.scan(din, n, got);
		u_scan_master_model.walk(8'h01, 2);
	end
	endtask

	task automatic t_power_up();
	begin
		chk("tdo after reset", 64'hZ, {64{tdo_pin}});
		u_scan_master_model.walk(8'h00, 1);
		scan_dr(64'h0, 32);
		chk("id shift", {32'h0, IDV}, got);
		chk("tdo idle", 64'hZ, {64{tdo_pin}});
	end
	endtask

	task automatic t_bypass();
	begin
		load_ir(INS_BYPASS);
		scan_dr(64'hB2, 8);
		chk("bypass path", 64'h64, got);
	end
	endtask

	task automatic t_boundary();
	begin
		io_ring = 16'hA5C3;
		load_ir(INS_SAMPLE);
		chk("sample hiz", 64'h0, {63'h0, pads_hiz});
		scan_dr(64'h3C5A, 32);
		chk("boundary path", 64'h3C5A_A5C3, got);
	end
	endtask

	// Float-output codes, then a mid-shift escape back to reset
	task automatic t_hiz_reset();
	begin
		load_ir(INS_SAMPLE_Z);
		chk("sample z hiz", 64'h1, {63'h0, pads_hiz});
		load_ir(INS_EXTEST);
		chk("extest hiz", 64'h1, {63'h0, pads_hiz});
		u_scan_master_model.walk(8'h01, 5);
		u_scan_master_model.reset_link();
		chk("hiz after reset", 64'h0, {63'h0, pads_hiz});
		u_scan_master_model.walk(8'h00, 1);
		scan_dr(64'h0, 32);
		chk("id after reset", {32'h0, IDV}, got);
	end
	endtask

	// Reserved code 101 acts as bypass; both scans are split by a pause
	task automatic t_reserved_pause();
	begin
		u_scan_master_model.walk(8'h03, 4);
		u_scan_master_model.scan(64'h1, 2, got);
		chk("ir capture low", 64'h1, got);
		u_scan_master_model.walk(8'h04, 4);
		u_scan_master_model.scan(64'h1, 1, got);
		chk("ir capture top", 64'h0, got);
		u_scan_master_model.walk(8'h05, 5);
		u_scan_master_model.scan(64'hA, 4, got);
		chk("reserved path", 64'h4, got);
		u_scan_master_model.walk(8'h04, 4);
		u_scan_master_model.scan(64'h6, 4, got);
		chk("bypass after pause", 64'hD, got);
		u_scan_master_model.walk(8'h01, 2);
		chk("tdo after pause", 64'hZ, {64{tdo_pin}});
	end
	endtask

	// Held-low test clock leaves everything still
	task automatic t_clock_held();
	begin
		repeat (300) @(negedge clk_sys);
		chk("tdo held", 64'hZ, {64{tdo_pin}});
	end
	endtask

	initial
	begin
		n_errors = 0;
		checked = 0;
		io_ring = 16'h0;
		reset_n = 1'h0;
		repeat (12) @(posedge clk_sys);
		@(negedge clk_sys);
		reset_n = 1'h1;
		t_power_up();
		t_bypass();
		t_boundary();
		t_hiz_reset();
		t_reserved_pause();
		t_clock_held();
		end_of_test();
	end

	// Whole run needs about 11 us; the limit leaves ample margin
	initial
	begin
		#100000;
		n_errors++;
		end_of_test();
	end
endmodule
`default_nettype wire
